// *** logic/switch_command_setup_sequencer.sv ***
/*
 Setup sequencer and output driver of the signal and indicator controller.
 Assumes switch commands arrive decoded, one-cycle valid, on i_mclk; the
 jumper and occupancy inputs are raw pins; configuration storage sits
 outside and takes o_cfg on o_cfg_wr.
*/
`timescale 1ns/1ps
`default_nettype none
`include "setup_seq_regs.svh"

module switch_command_setup_sequencer #(
    parameter int FLASH_HALF_CYC = `FLASH_HALF_CYC,
    parameter int CALC_CYC = `CALC_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_program_jumper_n,
    input wire setup_seq_pkg::sw_cmd_t i_cmd,
    input wire logic [7:0] i_occupancy_n,
    output logic [23:0] o_outputs,
    output logic o_setup_mode,
    output logic o_busy,
    output logic [7:0] o_occupied,
    output setup_seq_pkg::cfg_t o_cfg,
    output logic o_cfg_wr
);
    import setup_seq_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers and power-up strap
    // ------------------------------------------------------------------
    logic [1:0] jmp_r;
    logic [7:0] occ_s1_r, occ_s2_r;
    logic [1:0] cap_r, cap_nxt;
    logic setup_mode_r, setup_mode_nxt;

    always_comb begin
        cap_nxt = cap_r;
        setup_mode_nxt = setup_mode_r;
        if (cap_r != 2'h3) begin
            cap_nxt = cap_r + 2'h1;
            if (cap_r == 2'h2) begin
                setup_mode_nxt = ~jmp_r[1];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            jmp_r <= 2'h3;
            occ_s1_r <= 8'hff;
            occ_s2_r <= 8'hff;
            cap_r <= 2'h0;
            setup_mode_r <= 1'b0;
        end else begin
            jmp_r <= {jmp_r[0], i_program_jumper_n};
            occ_s1_r <= i_occupancy_n;
            occ_s2_r <= occ_s1_r;
            cap_r <= cap_nxt;
            setup_mode_r <= setup_mode_nxt;
        end
    end

    assign o_occupied = ~occ_s2_r;

    // ------------------------------------------------------------------
    // Setup sequence
    // ------------------------------------------------------------------
    state_t state_r, state_nxt;
    logic [2:0] step_r, step_nxt;
    logic [5:0] prog_r, prog_nxt;
    logic [5:0] opt_r, opt_nxt;
    logic [10:0] val_r [0:5];
    logic [10:0] val_nxt [0:5];
    logic [31:0] calc_r, calc_nxt;
    logic [3:0] sel_r, sel_nxt;
    cfg_t cfg_r, cfg_nxt;
    logic cfg_wr_r, cfg_wr_nxt;
    logic fl_start, fl_busy, fl_led;
    logic [2:0] fl_count;
    logic take;

    function automatic logic [10:0] opt_addr(input logic thrown, input logic [10:0] a);
        opt_addr = thrown ? a : 11'h000;
    endfunction : opt_addr

    // no source filtering; commands arriving during a flash burst are dropped
    assign take = i_cmd.valid && (state_r == S_STEP) && !fl_busy;

    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        prog_nxt = prog_r;
        opt_nxt = opt_r;
        val_nxt = val_r;
        calc_nxt = calc_r;
        sel_nxt = sel_r;
        cfg_nxt = cfg_r;
        cfg_wr_nxt = 1'b0;
        fl_start = 1'b0;
        fl_count = `ACK_FLASHES;
        case (state_r)
            S_RUN: begin
                if (setup_mode_r) begin
                    state_nxt = S_STEP;
                end
            end
            S_STEP: begin
                if (take && step_r != `PROG_STEPS) begin
                    val_nxt[step_r] = i_cmd.addr;
                    opt_nxt[step_r] = i_cmd.thrown;
                    fl_start = 1'b1;
                    prog_nxt[step_r] = 1'b1;
                    step_nxt = step_r + 3'h1;
                end else if (take && (!i_cmd.thrown || i_cmd.addr == 11'h000
                             || i_cmd.addr > 11'(`SETUP_MAX))) begin
                    fl_start = 1'b1;
                    fl_count = `ABORT_FLASHES;
                    step_nxt = 3'h0;
                    prog_nxt = 6'h00;
                end else if (take) begin
                    sel_nxt = i_cmd.addr[3:0];
                    fl_start = 1'b1;
                    fl_count = `SELECT_FLASHES;
                    state_nxt = S_ACK2;
                end
            end
            S_ACK2: begin
                calc_nxt = '0;
                if (!fl_busy) begin
                    state_nxt = S_CALC;
                end
            end
            S_CALC: begin
                calc_nxt = calc_r + 32'h1;
                if (calc_r == 32'(CALC_CYC - 1)) begin
                    cfg_nxt.base_addr = val_r[0];
                    cfg_nxt.out_msg_en = opt_r[0];
                    cfg_nxt.first_block = val_r[1];
                    cfg_nxt.in_en = opt_r[1];
                    cfg_nxt.num_blocks = (val_r[2] > 11'(`MAX_BLOCKS)) ?
                        `MAX_BLOCKS : val_r[2][2:0];
                    cfg_nxt.west_addr = opt_addr(opt_r[3], val_r[3]);
                    cfg_nxt.east_addr = opt_addr(opt_r[4], val_r[4]);
                    cfg_nxt.switch_addr = opt_addr(opt_r[5], val_r[5]);
                    cfg_nxt.setup_no = sel_r;
                    // anode for all but one setup
                    cfg_nxt.anode = (sel_r != `SETUP_CATHODE);
                    cfg_wr_nxt = 1'b1;
                    fl_start = 1'b1;
                    step_nxt = 3'h0;
                    prog_nxt = 6'h00;
                    state_nxt = S_STEP;
                end
            end
            default: begin
                state_nxt = S_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= S_RUN;
            step_r <= 3'h0;
            prog_r <= 6'h00;
            opt_r <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                val_r[i] <= 11'h000;
            end
            calc_r <= '0;
            sel_r <= 4'h0;
            cfg_r <= '{base_addr: `DEF_BASE_ADDR, first_block: `DEF_FIRST_BLOCK,
                       num_blocks: `MAX_BLOCKS, west_addr: 11'h000,
                       east_addr: 11'h000, switch_addr: 11'h000,
                       setup_no: `DEF_SETUP, anode: 1'b1, out_msg_en: 1'b1,
                       in_en: 1'b1};
            cfg_wr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            prog_r <= prog_nxt;
            opt_r <= opt_nxt;
            val_r <= val_nxt;
            calc_r <= calc_nxt;
            sel_r <= sel_nxt;
            cfg_r <= cfg_nxt;
            cfg_wr_r <= cfg_wr_nxt;
        end
    end

    led_flasher #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_start(fl_start),
        .i_count(fl_count),
        .o_busy(fl_busy),
        .o_led(fl_led)
    );

    // ------------------------------------------------------------------
    // Run mode: addressed outputs and block signalling
    // ------------------------------------------------------------------
    logic [23:0] cmd_out_r, cmd_out_nxt, lit, abs_lit, drv_r;
    logic [10:0] idx;

    assign idx = i_cmd.addr - cfg_r.base_addr;

    always_comb begin
        cmd_out_nxt = cmd_out_r;
        if (i_cmd.valid && !setup_mode_r && i_cmd.addr >= cfg_r.base_addr
            && idx < 11'(`NUM_OUTPUTS)) begin
            cmd_out_nxt[idx[4:0]] = i_cmd.thrown;
        end
    end

    // three-LED head per block: green, yellow, red
    always_comb begin
        abs_lit = 24'h000000;
        for (int k = 0; k < 4; k++) begin
            if (3'(k) < cfg_r.num_blocks) begin
                if (o_occupied[k] && cfg_r.in_en) begin
                    abs_lit[3*k+2] = 1'b1;
                end else if (3'(k + 1) < cfg_r.num_blocks && o_occupied[k+1]
                             && cfg_r.in_en) begin
                    abs_lit[3*k+1] = 1'b1;
                end else begin
                    abs_lit[3*k] = 1'b1;
                end
            end
        end
    end

    always_comb begin
        if (setup_mode_r) begin
            lit = {18'h00000, prog_r ^ {6{fl_led}}};
        end else if (cfg_r.setup_no == `DEF_SETUP) begin
            lit = abs_lit;
        end else begin
            lit = cmd_out_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_out_r <= 24'h000000;
            drv_r <= 24'hffffff;
        end else begin
            cmd_out_r <= cmd_out_nxt;
            drv_r <= cfg_r.anode ? ~lit : lit;
        end
    end

    assign o_outputs = drv_r;
    assign o_setup_mode = setup_mode_r;
    assign o_busy = fl_busy || state_r == S_ACK2 || state_r == S_CALC;
    assign o_cfg = cfg_r;
    assign o_cfg_wr = cfg_wr_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    sequence seq_step_take;
        take && step_r != `PROG_STEPS;
    endsequence

    sequence seq_final_abort;
        take && step_r == `PROG_STEPS && !i_cmd.thrown;
    endsequence

    AST_RUN_NO_STEP: assert property (!setup_mode_r |-> step_r == 3'h0 && !o_cfg_wr)
        else $error("step moved outside setup mode");
    AST_STEP_ACK: assert property (seq_step_take |-> fl_start && fl_count == 3'h1)
        else $error("step not acknowledged by one flash");
    AST_STEP_ADV: assert property (seq_step_take |=> step_r == $past(step_r) + 3'h1
        && prog_r[$past(step_r)])
        else $error("progress output not lit");
    AST_SELECT: assert property (take && step_r == `PROG_STEPS && i_cmd.thrown
        && i_cmd.addr == 11'h001 |-> fl_count == 3'h2 ##1 state_r == S_ACK2)
        else $error("selection not taken with two flashes");
    AST_ABORT: assert property (seq_final_abort |-> fl_count == 3'h5
        ##1 (step_r == 3'h0 && prog_r == 6'h00 && state_r == S_STEP))
        else $error("abort did not restart");
    AST_SUCCESS: assert property (o_cfg_wr |-> step_r == 3'h0 && prog_r == 6'h00
        && fl_busy)
        else $error("success did not clear progress");
    AST_POLARITY: assert property (o_cfg_wr |-> o_cfg.anode == (o_cfg.setup_no != 4'h5))
        else $error("polarity wrong for setup");
    AST_OCCUPY: assert property ($fell(i_occupancy_n[0]) ##1 !i_occupancy_n[0]
        ##1 !i_occupancy_n[0] |-> o_occupied[0])
        else $error("low input not seen as occupied");
    AST_ADDR_MAP: assert property (i_cmd.valid && !setup_mode_r && i_cmd.thrown
        && i_cmd.addr == cfg_r.base_addr |=> cmd_out_r[0])
        else $error("base address does not reach output 1");

endmodule : switch_command_setup_sequencer

`default_nettype wire

// *** logic/setup_seq_regs.svh ***
/*
 Constants for the switch command setup sequencer: step counts, factory
 defaults and timing counts. Assumes a 40 MHz master clock.
*/
`ifndef SETUP_SEQ_REGS_SVH
`define SETUP_SEQ_REGS_SVH

// ----------------------------------------------------------------------
// Setup sequence
// ----------------------------------------------------------------------
`define PROG_STEPS 3'h6
`define NUM_OUTPUTS 24
`define NUM_INPUTS 8
`define MAX_BLOCKS 3'h4
`define SETUP_MAX 4'h8
`define SETUP_CATHODE 4'h5
`define ABORT_FLASHES 3'h5
`define SELECT_FLASHES 3'h2
`define ACK_FLASHES 3'h1

// ----------------------------------------------------------------------
// Factory defaults
// ----------------------------------------------------------------------
`define DEF_BASE_ADDR 11'h065
`define DEF_FIRST_BLOCK 11'h001
`define DEF_SETUP 4'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MCLK_HZ 40000000
`define FLASH_HALF_MS 250
`define CALC_MS 100
`define FLASH_HALF_CYC ((`MCLK_HZ / 1000) * `FLASH_HALF_MS)
`define CALC_CYC ((`MCLK_HZ / 1000) * `CALC_MS)

`endif

// *** logic/setup_seq_pkg.sv ***
/*
 Types for the switch command setup sequencer.
 Assumes the bus decoder delivers switch commands on the same clock.
*/
`default_nettype none

package setup_seq_pkg;

    typedef struct packed {
        logic valid;
        logic [10:0] addr;
        logic thrown;
    } sw_cmd_t;

    typedef struct packed {
        logic [10:0] base_addr;
        logic [10:0] first_block;
        logic [2:0] num_blocks;
        logic [10:0] west_addr;
        logic [10:0] east_addr;
        logic [10:0] switch_addr;
        logic [3:0] setup_no;
        logic anode;
        logic out_msg_en;
        logic in_en;
    } cfg_t;

    typedef enum logic [2:0] {
        S_RUN = 3'b000,
        S_STEP = 3'b001,
        S_ACK2 = 3'b010,
        S_CALC = 3'b011
    } state_t;

endpackage : setup_seq_pkg

`default_nettype wire

// *** logic/led_flasher.sv ***
/*
 Flash generator: emits a given number of on/off flashes.
 Assumes start is a one-cycle pulse on the same clock; a start while
 busy restarts the burst.
*/
`timescale 1ns/1ps
`default_nettype none

module led_flasher #(
    parameter int HALF_CYC = 10000000
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic [2:0] i_count,
    output logic o_busy,
    output logic o_led
);
    logic [31:0] tick_r, tick_nxt;
    logic [3:0] half_r, half_nxt;

    always_comb begin
        tick_nxt = tick_r;
        half_nxt = half_r;
        if (i_start) begin
            tick_nxt = '0;
            half_nxt = {i_count, 1'b0};
        end else if (half_r != 4'h0) begin
            if (tick_r == 32'(HALF_CYC - 1)) begin
                tick_nxt = '0;
                half_nxt = half_r - 4'h1;
            end else begin
                tick_nxt = tick_r + 32'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_r <= '0;
            half_r <= '0;
        end else begin
            tick_r <= tick_nxt;
            half_r <= half_nxt;
        end
    end

    assign o_busy = (half_r != 4'h0);
    // Odd half counts are the lit phase; a burst opens dark so an LED
    // that is already on still shows every flash
    assign o_led = half_r[0];

endmodule : led_flasher

`default_nettype wire

// *** tb/throttle_model.sv ***
/*
 Throttle and command station model: issues decoded switch commands.
 Assumes the sequencer samples the command on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module throttle_model (
    input wire logic i_mclk,
    output var setup_seq_pkg::sw_cmd_t o_cmd
);
    import setup_seq_pkg::*;

    initial begin
        o_cmd = '0;
    end

    // one throttle, t or c
    // Single sender: a second source would interleave the steps
    task automatic send(input logic [10:0] addr, input logic thrown);
        @(negedge i_mclk);
        o_cmd.valid = 1'b1;
        o_cmd.addr = addr;
        o_cmd.thrown = thrown;
        @(negedge i_mclk);
        o_cmd.valid = 1'b0;
        // Stale fields are scrambled so nothing relies on them
        o_cmd.addr = ~addr;
        o_cmd.thrown = ~thrown;
    endtask : send
endmodule : throttle_model

`default_nettype wire

// *** tb/switch_command_setup_sequencer_tb.sv ***
/*
 Testbench of the setup sequencer: run-mode signalling and guided setup.
 Assumes reduced flash and pause counts and a throttle model on i_cmd.
*/
`timescale 1ns/1ps
`default_nettype none

module switch_command_setup_sequencer_tb;
    import setup_seq_pkg::*;
    logic i_mclk;
    logic i_arst_n;
    logic i_program_jumper_n;
    sw_cmd_t cmd;
    logic [7:0] i_occupancy_n;
    logic [23:0] o_outputs;
    logic o_setup_mode;
    logic o_busy;
    logic [7:0] o_occupied;
    cfg_t o_cfg;
    logic o_cfg_wr;
    int error_cnt = 0;
    int n_checks = 0;
    int tog_cnt = 0;
    int wr_cnt = 0;
    logic prev5;
    logic anode_exp;
    cfg_t cfg_seen;
    logic [10:0] st_addr [6] = '{11'h07d, 11'h005, 11'h003, 11'h04d, 11'h07a, 11'h009};
    logic st_thr [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    always #12.5 i_mclk = ~i_mclk;

    switch_command_setup_sequencer #(.FLASH_HALF_CYC(4), .CALC_CYC(3)) DUT (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_program_jumper_n(i_program_jumper_n),
        .i_cmd(cmd),
        .i_occupancy_n(i_occupancy_n),
        .o_outputs(o_outputs),
        .o_setup_mode(o_setup_mode),
        .o_busy(o_busy),
        .o_occupied(o_occupied),
        .o_cfg(o_cfg),
        .o_cfg_wr(o_cfg_wr)
    );

    throttle_model thr (
        .i_mclk(i_mclk),
        .o_cmd(cmd)
    );

    // ----------------------------------------------------------------
    // Monitors and helpers
    // ----------------------------------------------------------------
    // Flashes are counted as toggles of output 6, which progress sets only once
    always @(posedge i_mclk) begin
        if (o_outputs[5] !== prev5) tog_cnt++;
        prev5 = o_outputs[5];
        if (o_cfg_wr === 1'b1) begin
            wr_cnt++;
            cfg_seen = o_cfg;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [5:0] prog_exp(input int n);
        logic [5:0] m;
        m = 6'h3f << n;
        return anode_exp ? m : ~m;
    endfunction : prog_exp

    task automatic do_reset(input logic jumper);
        @(negedge i_mclk);
        i_arst_n = 1'b0;
        i_program_jumper_n = ~jumper;
        repeat (10) @(negedge i_mclk);
        i_arst_n = 1'b1;
        repeat (8) @(negedge i_mclk);
    endtask : do_reset

    task automatic step(input logic [10:0] a, input logic t, input bit extra, output int tog);
        int t0;
        int idle;
        t0 = tog_cnt;
        thr.send(a, t);
        if (extra) begin
            repeat (2) @(negedge i_mclk);
            thr.send(a, t);
        end
        idle = 0;
        for (int i = 0; i < 400 && idle < 4; i++) begin
            @(negedge i_mclk);
            idle = (o_busy === 1'b0) ? idle + 1 : 0;
        end
        chk("busy end", idle, 4);
        tog = tog_cnt - t0;
    endtask : step

    task automatic program_setup(input logic [3:0] sel, input logic t7, input bit ct);
        int tg;
        int wr0;
        for (int n = 1; n <= 6; n++) begin
            step(st_addr[n-1], st_thr[n-1], (n == 1 && ct && !t7), tg);
            chk("progress", o_outputs[5:0], prog_exp(n));
            if (ct) chk("step flashes", tg, (n == 6) ? 3 : 2);
        end
        wr0 = wr_cnt;
        step({7'h00, sel}, t7, 1'b0, tg);
        if (t7) begin
            anode_exp = (sel != 4'h5);
            chk("cfg write", wr_cnt - wr0, 1);
            chk("setup no", cfg_seen.setup_no, sel);
            chk("polarity", cfg_seen.anode, anode_exp);
            if (ct) begin
                chk("select flashes", tg, 7);
                chk("base", cfg_seen.base_addr, 11'h07d);
                chk("first", cfg_seen.first_block, 11'h005);
                chk("blocks", cfg_seen.num_blocks, 3'h3);
                chk("west skip", cfg_seen.west_addr, 11'h000);
                chk("east", cfg_seen.east_addr, 11'h07a);
                chk("switch skip", cfg_seen.switch_addr, 11'h000);
                chk("enables", {cfg_seen.out_msg_en, cfg_seen.in_en}, 2'b11);
            end
        end else begin
            chk("no cfg write", wr_cnt - wr0, 0);
            if (ct) chk("abort flashes", tg, 11);
        end
        chk("progress clear", o_outputs[5:0], prog_exp(0));
    endtask : program_setup

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_run_mode();
        do_reset(1'b0);
        chk("setup mode", o_setup_mode, 1'b0);
        chk("base", o_cfg.base_addr, 11'h065);
        chk("first", o_cfg.first_block, 11'h001);
        chk("blocks", o_cfg.num_blocks, 3'h4);
        chk("setup no", o_cfg.setup_no, 4'h1);
        repeat (4) @(negedge i_mclk);
        chk("clear aspects", o_outputs[5:0], 6'h36);
        chk("dark heads", o_outputs[23:12], 12'hfff);
        thr.send(11'h065, 1'b1);
        thr.send(11'h07c, 1'b1);
        thr.send(11'h07d, 1'b1);
        thr.send(11'h064, 1'b1);
        repeat (2) @(negedge i_mclk);
        chk("addr map", DUT.cmd_out_r, 24'h800001);
        chk("signals keep", o_outputs[5:0], 6'h36);
        i_occupancy_n = 8'hfd;
        repeat (4) @(negedge i_mclk);
        chk("occupied", o_occupied, 8'h02);
        chk("red yellow", o_outputs[5:0], 6'h1d);
        i_occupancy_n = 8'hfe;
        repeat (4) @(negedge i_mclk);
        chk("occupied first", o_occupied, 8'h01);
        chk("red first", o_outputs[5:0], 6'h33);
        i_occupancy_n = 8'hff;
        i_program_jumper_n = 1'b0;
        repeat (6) @(negedge i_mclk);
        chk("late jumper", o_setup_mode, 1'b0);
        $display("test run_mode done");
    endtask : test_run_mode

    task automatic test_setup();
        do_reset(1'b1);
        // Jumper may come off; only power-up sampling counts
        i_program_jumper_n = 1'b1;
        repeat (6) @(negedge i_mclk);
        chk("setup mode", o_setup_mode, 1'b1);
        anode_exp = 1'b1;
        chk("no progress", o_outputs[5:0], prog_exp(0));
        program_setup(4'h1, 1'b0, 1'b1);
        program_setup(4'h1, 1'b1, 1'b1);
        // cathode preset carried
        // Setup 5 leaves cathode polarity, so the setup 6 run displays upright
        for (int s = 2; s <= 8; s++) begin
            program_setup(4'(s), 1'b1, 1'b0);
        end
        $display("test setup done");
    endtask : test_setup

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    initial begin
        i_mclk = 1'b0;
        i_arst_n = 1'b0;
        i_program_jumper_n = 1'b1;
        i_occupancy_n = 8'hff;
        prev5 = 1'b1;
        anode_exp = 1'b1;
        test_run_mode();
        test_setup();
        final_report();
    end

    // Whole run is near 1100 cycles; 10000 leaves ample margin
    initial begin
        #250000;
        error_cnt++;
        $display("FAIL watchdog expected done seen timeout");
        final_report();
    end
endmodule : switch_command_setup_sequencer_tb

`default_nettype wire
